// *** operand_map.svh ***
// Purpose: Named constants for the operand address resolver.
// Assumes: BCD designations, 16-bit data words.
// Notes: Definitions only.
`ifndef OPERAND_MAP_SVH
`define OPERAND_MAP_SVH
`define WORD_WIDTH      16
`define DIGIT_WIDTH     4
`define DIGIT_COUNT     4
`define BCD_MAX_DIGIT   4'h9
`define BIT_TENS_MAX    4'h1
`define BIT_UNITS_MAX   4'h5
`define RET_WORDS       16
`define IO_WORDS        32
`define LINK_WORDS      8
`define TC_COUNT        16
`define RET_RESET_WORD  16'h0000
`define RET_END_BCD     16'h0016
`endif

// *** operand_pkg.sv ***
// Purpose: Types shared by the operand address resolver.
// Assumes: Nothing beyond the constant header.
// Notes: Areas, access kinds and the request carrier.
package operand_pkg;
    typedef enum logic [1:0] {
        AREA_PLAIN,
        AREA_RETENTIVE,
        AREA_LINK,
        AREA_TIMER
    } area_type;

    typedef struct packed {
        area_type    area;
        logic        isBit;
        logic        indirect;
        logic        write;
        logic        needBcd;
        logic [15:0] designation;
        logic [15:0] writeData;
    } request_type;

    typedef struct packed {
        logic        fault;
        logic        bitValue;
        logic [15:0] wordValue;
    } answer_type;
endpackage

// *** plc_operand_address_resolver.sv ***
// Purpose: Resolves operand designations into word and bit accesses of data memory.
// Assumes: One request at a time, sampled only in the cycle it is accepted.
// Notes: Data memory lives here as arrays; retention over power loss is the array itself.
`timescale 1ns/100ps
`default_nettype none
`include "operand_map.svh"

module plc_operand_address_resolver (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      reqValid,
    input  wire operand_pkg::request_type  req,
    input  wire logic [`TC_COUNT-1:0]      timerDone,
    input  wire logic [`WORD_WIDTH-1:0]    timerCount [`TC_COUNT],
    output logic                           reqReady,
    output logic                           ansValid,
    output operand_pkg::answer_type        ans,
    output logic                           operandFaultFlag
);
    typedef enum logic [1:0] {S_IDLE, S_POINTER, S_ACCESS, S_DONE} state_type;

    // Each area is an array of 16-bit words; timers are outside and only read here.
    logic [`WORD_WIDTH-1:0] plainMem [`IO_WORDS];
    logic [`WORD_WIDTH-1:0] retentiveArea [`RET_WORDS];
    logic [`WORD_WIDTH-1:0] linkArea [`LINK_WORDS];

    state_type               state_reg;
    state_type               state_next;
    operand_pkg::request_type held_reg;
    logic [7:0]              wordSel_reg;
    logic                    fault_reg;
    operand_pkg::answer_type ans_reg;
    logic                    faultFlag_reg;

    function automatic logic bcd_ok(input logic [`WORD_WIDTH-1:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `DIGIT_COUNT; i++) begin
            if (w[i*`DIGIT_WIDTH +: `DIGIT_WIDTH] > `BCD_MAX_DIGIT) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Tens digit times ten plus units; a digit above nine is caught by bcd_ok, not here, except in the word number of a timer bit, which is never checked.
    function automatic logic [7:0] bcd_to_bin(input logic [7:0] b);
        return 8'(b[7:4]) * 8'h0A + 8'(b[3:0]);
    endfunction

    // Word number is the upper two BCD digits of a bit designation outside the timer area, else the lower two.
    logic [7:0] reqWordBcd;
    logic [3:0] bitTens;
    logic [3:0] bitUnits;
    logic       bitLegal;
    logic [3:0] bitIndex;
    logic       wordFits;
    logic [7:0] wordNum;

    always_comb begin
        reqWordBcd = req.isBit ? req.designation[15:8] : req.designation[7:0];
        bitTens    = req.designation[7:4];
        bitUnits   = req.designation[3:0];
        bitLegal   = (bitTens <= `BIT_TENS_MAX) && (bitUnits <= `BIT_UNITS_MAX);
        bitIndex   = 4'(bitTens * 4'hA + bitUnits);
        wordNum    = bcd_to_bin(reqWordBcd);
    end

    always_comb begin
        unique case (held_reg.area)
            operand_pkg::AREA_RETENTIVE: wordFits = wordSel_reg < 8'(`RET_WORDS);
            operand_pkg::AREA_LINK:      wordFits = wordSel_reg < 8'(`LINK_WORDS);
            operand_pkg::AREA_TIMER:     wordFits = wordSel_reg < 8'(`TC_COUNT);
            default:                     wordFits = wordSel_reg < 8'(`IO_WORDS);
        endcase
    end

    assign reqReady = (state_reg == S_IDLE);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (reqValid) begin
                    state_next = (req.indirect && req.area == operand_pkg::AREA_RETENTIVE)
                               ? S_POINTER : S_ACCESS;
                end
            end
            S_POINTER: state_next = S_ACCESS;
            S_ACCESS:  state_next = S_DONE;
            S_DONE:    state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Capture the request and resolve the first word selection.
    always_ff @(posedge clk) begin
        if (srst) begin
            held_reg    <= '0;
            wordSel_reg <= 8'h00;
            fault_reg   <= 1'b0;
        end else if (state_reg == S_IDLE && reqValid) begin
            held_reg    <= req;
            wordSel_reg <= (req.isBit && req.area != operand_pkg::AREA_TIMER)
                         ? wordNum : bcd_to_bin(req.designation[7:0]);
            fault_reg   <= !bcd_ok({8'h00, reqWordBcd})
                         || (req.isBit && req.area != operand_pkg::AREA_TIMER && !bitLegal)
                         || (req.needBcd && !req.indirect && req.write
                             && !bcd_ok(req.writeData));
            // Keep only the bit number so that later stages need no second decode.
            if (req.isBit) begin
                held_reg.designation <= {12'h000, bitIndex};
            end
        end else if (state_reg == S_POINTER) begin
            // A bad pointer is caught before the second access is tried.
            // The pointer's own word number is range checked too, since a wrapped index
            // would quietly read some other retentive word as the pointer.
            if (!bcd_ok(retentiveArea[wordSel_reg[3:0]])
                || bcd_to_bin(retentiveArea[wordSel_reg[3:0]][7:0]) >= 8'(`RET_WORDS)
                || retentiveArea[wordSel_reg[3:0]][15:8] != 8'h00
                || !wordFits) begin
                fault_reg <= 1'b1;
            end
            wordSel_reg <= bcd_to_bin(retentiveArea[wordSel_reg[3:0]][7:0]);
        end else if (state_reg == S_ACCESS && !wordFits) begin
            fault_reg <= 1'b1;
        end
    end

    // Selected word as currently stored; the timer area yields its present count value.
    logic [`WORD_WIDTH-1:0] curWord;
    logic [`WORD_WIDTH-1:0] newWord;
    logic                   doAccess;
    logic                   readBad;
    logic                   timerBitPick;
    logic [`WORD_WIDTH-1:0] timerWordPick;

    always_comb begin
        curWord = '0;
        if (wordFits) begin
            unique case (held_reg.area)
                operand_pkg::AREA_RETENTIVE: curWord = retentiveArea[wordSel_reg[3:0]];
                operand_pkg::AREA_LINK:      curWord = linkArea[wordSel_reg[2:0]];
                operand_pkg::AREA_TIMER:     curWord = timerCount[wordSel_reg[3:0]];
                default:                     curWord = plainMem[wordSel_reg[4:0]];
            endcase
        end
        newWord = held_reg.writeData;
        if (held_reg.isBit) begin
            newWord = curWord;
            newWord[held_reg.designation[3:0]] = held_reg.writeData[0];
        end
        doAccess = (state_reg == S_ACCESS) && wordFits && !fault_reg;
        readBad  = doAccess && held_reg.needBcd && !held_reg.write && !held_reg.isBit
                 && !bcd_ok(curWord);
        timerBitPick  = timerDone[wordSel_reg[3:0]];
        timerWordPick = timerCount[wordSel_reg[3:0]];
    end

    // Stores are whole words; the timer area is never written from here.
    always_ff @(posedge clk) begin
        if (doAccess && held_reg.write) begin
            unique case (held_reg.area)
                operand_pkg::AREA_RETENTIVE: retentiveArea[wordSel_reg[3:0]] <= newWord;
                operand_pkg::AREA_LINK:      linkArea[wordSel_reg[2:0]] <= newWord;
                operand_pkg::AREA_TIMER:     ;
                default:                     plainMem[wordSel_reg[4:0]] <= newWord;
            endcase
        end
    end

    // Answer data; word read unmodified, BCD checked only where asked for.
    always_ff @(posedge clk) begin
        if (srst) begin
            ans_reg <= '0;
        end else if (state_reg == S_ACCESS) begin
            // A word operand answers with a zero bit value, so no stale bit looks like data.
            ans_reg.wordValue <= (doAccess && !readBad) ? curWord : '0;
            ans_reg.bitValue  <= doAccess && !readBad && held_reg.isBit
                               && (held_reg.area == operand_pkg::AREA_TIMER
                                   ? timerBitPick
                                   : curWord[held_reg.designation[3:0]]);
            ans_reg.fault     <= fault_reg || !wordFits || readBad;
        end
    end

    // The sticky flag is held until the engine ends its scan with a new reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            faultFlag_reg <= 1'b0;
        end else if (state_reg == S_DONE && ans_reg.fault) begin
            faultFlag_reg <= 1'b1;
        end
    end

    assign ansValid         = (state_reg == S_DONE);
    assign ans              = ans_reg;
    assign operandFaultFlag = faultFlag_reg;

    chk_pointer_bad_faults: assert property (@(posedge clk) disable iff (srst)
        state_reg == S_POINTER && !bcd_ok(retentiveArea[wordSel_reg[3:0]])
        |=> ##1 ans_reg.fault && ansValid)
        else $error("Bad pointer gave no fault.");
    chk_bit_range_legal: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && req.isBit && req.area != operand_pkg::AREA_TIMER
        && req.designation[3:0] > `BIT_UNITS_MAX |-> ##3 ans.fault)
        else $error("Illegal bit number accepted.");
    chk_answer_latency: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && !req.indirect |-> ##2 ansValid)
        else $error("Direct answer not on third cycle.");
    chk_indirect_latency: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && req.indirect && req.area == operand_pkg::AREA_RETENTIVE
        |-> !ansValid [*3] ##1 ansValid)
        else $error("Indirect answer not on fourth cycle.");
    chk_fault_sticky: assert property (@(posedge clk) disable iff (srst)
        ansValid && ans.fault |=> operandFaultFlag)
        else $error("Fault flag not raised.");
    chk_flag_holds: assert property (@(posedge clk) disable iff (srst)
        operandFaultFlag |=> operandFaultFlag)
        else $error("Fault flag dropped without reset.");
    chk_faulted_no_value: assert property (@(posedge clk) disable iff (srst)
        ansValid && fault_reg |-> ans.wordValue == '0)
        else $error("Faulted access returned data.");
    chk_timer_bit_done: assert property (@(posedge clk) disable iff (srst)
        state_reg == S_ACCESS && doAccess && held_reg.isBit
        && held_reg.area == operand_pkg::AREA_TIMER
        |=> ans.bitValue == $past(timerBitPick))
        else $error("Timer bit is not its completion flag.");
    chk_ready_idle: assert property (@(posedge clk) disable iff (srst)
        ansValid |=> reqReady)
        else $error("Not ready after answer.");
    chk_bit_tens_legal: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && req.isBit && !req.indirect
        && req.area != operand_pkg::AREA_TIMER && req.designation[7:4] > `BIT_TENS_MAX
        |-> ##2 ansValid && ans.fault)
        else $error("Illegal bit tens digit accepted.");
    chk_link_range: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && !req.indirect && !req.isBit
        && req.area == operand_pkg::AREA_LINK && req.designation[7:0] >= 8'(`LINK_WORDS)
        |-> ##2 ansValid && ans.fault)
        else $error("Word beyond the link area accepted.");
    chk_fault_zero_data: assert property (@(posedge clk) disable iff (srst)
        ansValid && ans.fault |-> ans.wordValue == '0 && !ans.bitValue)
        else $error("Faulted answer carried data.");
    chk_bcd_write_refused: assert property (@(posedge clk) disable iff (srst)
        reqValid && reqReady && !req.indirect && req.needBcd && req.write
        && !bcd_ok(req.writeData) |-> ##2 ansValid && ans.fault)
        else $error("Non-BCD write data accepted.");
    chk_pointer_range: assert property (@(posedge clk) disable iff (srst)
        state_reg == S_POINTER && bcd_ok(retentiveArea[wordSel_reg[3:0]])
        && retentiveArea[wordSel_reg[3:0]] >= `RET_END_BCD
        |=> ##1 ansValid && ans.fault)
        else $error("Pointer beyond the retentive area gave no fault.");
    chk_reset_quiet: assert property (@(posedge clk)
        srst |=> reqReady && !ansValid && !operandFaultFlag && ans == '0)
        else $error("Outputs not quiet after reset.");
    chk_answer_pulse: assert property (@(posedge clk) disable iff (srst)
        ansValid |=> !ansValid)
        else $error("Answer valid held longer than one cycle.");
    chk_bit_write_single: assert property (@(posedge clk) disable iff (srst)
        doAccess && held_reg.isBit && held_reg.write |-> $countones(newWord ^ curWord) <= 1)
        else $error("Bit write changed more than one bit.");
    chk_word_no_bit: assert property (@(posedge clk) disable iff (srst)
        ansValid && !held_reg.isBit |-> !ans.bitValue)
        else $error("Word answer carried a bit value.");
    chk_flag_only_fault: assert property (@(posedge clk) disable iff (srst)
        !operandFaultFlag && !(ansValid && ans.fault) |=> !operandFaultFlag)
        else $error("Fault flag rose without a faulted answer.");
    chk_timer_word_count: assert property (@(posedge clk) disable iff (srst)
        state_reg == S_ACCESS && doAccess && !held_reg.isBit && !held_reg.needBcd
        && held_reg.area == operand_pkg::AREA_TIMER
        |=> ans.wordValue == $past(timerWordPick))
        else $error("Timer word is not its present count value.");

    cov_direct_word: cover property (@(posedge clk) ansValid && !held_reg.isBit && !ans.fault);
    cov_indirect_ok: cover property (@(posedge clk) ansValid && held_reg.indirect && !ans.fault);
    cov_bit_write: cover property (@(posedge clk) doAccess && held_reg.isBit && held_reg.write);
    cov_fault_seen: cover property (@(posedge clk) ansValid && ans.fault);
    cov_bcd_refused: cover property (@(posedge clk) ansValid && ans.fault && held_reg.needBcd);
endmodule
`default_nettype wire

// *** operand_engine_model.sv ***
// Purpose: Behavioural model of the instruction engine that issues operand requests.
// Assumes: One request at a time, driven 1 ns after the rising edge.
// Notes: A released request bus shows the inverse of the last request, never a stale copy.
`timescale 1ns/100ps
`default_nettype none

module operand_engine_model (
    input  wire logic                     clk,
    input  wire logic                     reqReady,
    input  wire logic                     ansValid,
    input  wire operand_pkg::answer_type  ans,
    output logic                          reqValid,
    output operand_pkg::request_type      req
);
    initial begin
        reqValid = 1'b0;
        req      = '0;
    end

    // Retentive, link and timer requests always carry their area code.
    // Bit designations are issued with their bit digits as the caller gives them.
    task automatic issue(input operand_pkg::request_type r,
                         output operand_pkg::answer_type a, output logic ok);
        int n;
        n = 0;
        reqValid = 1'b1;
        req      = r;
        while (reqReady !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        req      = ~r;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ansValid !== 1'b1 && n < 8);
        ok = (n < 8);
        a  = ans;
        @(posedge clk);
        #1;
    endtask
endmodule

`default_nettype wire

// *** plc_operand_address_resolver_tb.sv ***
// Purpose: Self-checking bench for the operand address resolver.
// Assumes: Memory holds no reset value, so every word is written before it is read.
// Notes: Fractional and arithmetic handling does not show at these ports and is left out.
`timescale 1ns/100ps
`default_nettype none
`include "operand_map.svh"
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module plc_operand_address_resolver_tb;
    logic                     clk = 1'b0;
    logic                     srst = 1'b1;
    logic                     reqValid;
    operand_pkg::request_type req;
    logic [`TC_COUNT-1:0]     timerDone = '0;
    logic [`WORD_WIDTH-1:0]   timerCount [`TC_COUNT];
    logic                     reqReady;
    logic                     ansValid;
    operand_pkg::answer_type  ans;
    logic                     operandFaultFlag;
    operand_pkg::answer_type  got;
    int                       miscompares = 0;
    int                       totalChecks = 0;
    int                       cycles = 0;

    always #2 clk = ~clk;

    plc_operand_address_resolver u_plc_operand_address_resolver (
        .clk(clk), .srst(srst), .reqValid(reqValid), .req(req), .timerDone(timerDone),
        .timerCount(timerCount), .reqReady(reqReady), .ansValid(ansValid), .ans(ans),
        .operandFaultFlag(operandFaultFlag));

    operand_engine_model u_operand_engine_model (
        .clk(clk), .reqReady(reqReady), .ansValid(ansValid), .ans(ans),
        .reqValid(reqValid), .req(req));

    task automatic completeRun();
        if (miscompares == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling is far above the roughly 135 cycles the scenarios need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            completeRun();
        end
    end

    task automatic doReset();
        srst = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        srst = 1'b0;
    endtask

    // Flags k are isBit, indirect, write, needBcd from left to right.
    task automatic xfer(input operand_pkg::area_type ar, input logic [3:0] k,
                        input logic [15:0] d, input logic [15:0] w);
        operand_pkg::request_type r;
        logic ok;
        r = {ar, k, d, w};
        u_operand_engine_model.issue(r, got, ok);
        `CHECK(ok, 1'b1)
        `CHECK(reqReady, 1'b1)
    endtask

    task automatic wordOps();
        xfer(operand_pkg::AREA_PLAIN, 4'h2, 16'h0012, 16'h5F5F);
        xfer(operand_pkg::AREA_PLAIN, 4'h0, 16'h0012, 16'h0000);
        `CHECK(got, 18'h05F5F)
        xfer(operand_pkg::AREA_LINK, 4'h2, 16'h0007, 16'hA5C3);
        xfer(operand_pkg::AREA_RETENTIVE, 4'h2, 16'h0015, 16'h1234);
        xfer(operand_pkg::AREA_LINK, 4'h0, 16'h0007, 16'h0000);
        `CHECK(got, 18'h0A5C3)
        xfer(operand_pkg::AREA_RETENTIVE, 4'h1, 16'h0015, 16'h0000);
        `CHECK(got, 18'h01234)
    endtask

    task automatic bitOps();
        xfer(operand_pkg::AREA_PLAIN, 4'h2, 16'h0012, 16'h0000);
        xfer(operand_pkg::AREA_PLAIN, 4'hA, 16'h1215, 16'h0001);
        xfer(operand_pkg::AREA_PLAIN, 4'hA, 16'h1200, 16'h0001);
        xfer(operand_pkg::AREA_PLAIN, 4'h0, 16'h0012, 16'h0000);
        `CHECK(got.wordValue, 16'h8001)
        xfer(operand_pkg::AREA_PLAIN, 4'h8, 16'h1215, 16'h0000);
        `CHECK(got.bitValue, 1'b1)
        xfer(operand_pkg::AREA_PLAIN, 4'h8, 16'h1214, 16'h0000);
        `CHECK(got.bitValue, 1'b0)
    endtask

    task automatic timerOps();
        timerCount[3] = 16'h0123;
        timerDone[3]  = 1'b1;
        xfer(operand_pkg::AREA_TIMER, 4'h0, 16'h0003, 16'h0000);
        `CHECK(got, 18'h00123)
        xfer(operand_pkg::AREA_TIMER, 4'h8, 16'h0003, 16'h0000);
        `CHECK(got.bitValue, 1'b1)
        timerDone[3] = 1'b0;
        xfer(operand_pkg::AREA_TIMER, 4'h8, 16'h0003, 16'h0000);
        `CHECK(got.bitValue, 1'b0)
    endtask

    task automatic indirectOps();
        xfer(operand_pkg::AREA_RETENTIVE, 4'h2, 16'h0001, 16'h0006);
        xfer(operand_pkg::AREA_RETENTIVE, 4'h2, 16'h0006, 16'h5757);
        xfer(operand_pkg::AREA_RETENTIVE, 4'h4, 16'h0001, 16'h0000);
        `CHECK(got, 18'h05757)
        `CHECK(operandFaultFlag, 1'b0)
    endtask

    // Each entry must fault with no data and, for the write, leave word 12 alone.
    task automatic faultOps();
        operand_pkg::area_type ar [8];
        logic [3:0]            k  [8];
        logic [15:0]           d  [8];
        ar = '{operand_pkg::AREA_PLAIN, operand_pkg::AREA_PLAIN, operand_pkg::AREA_RETENTIVE,
               operand_pkg::AREA_PLAIN, operand_pkg::AREA_RETENTIVE,
               operand_pkg::AREA_RETENTIVE, operand_pkg::AREA_PLAIN, operand_pkg::AREA_LINK};
        k  = '{4'h8, 4'h8, 4'h0, 4'h1, 4'h4, 4'h4, 4'hA, 4'h0};
        d  = '{16'h0116, 16'h0120, 16'h0016, 16'h0013, 16'h0002, 16'h0003, 16'h1216, 16'h0008};
        xfer(operand_pkg::AREA_PLAIN, 4'h2, 16'h0013, 16'h000B);
        xfer(operand_pkg::AREA_PLAIN, 4'h0, 16'h0013, 16'h0000);
        `CHECK(got, 18'h0000B)
        xfer(operand_pkg::AREA_RETENTIVE, 4'h2, 16'h0002, 16'h0016);
        xfer(operand_pkg::AREA_RETENTIVE, 4'h2, 16'h0003, 16'h000A);
        for (int i = 0; i < 8; i++) begin
            xfer(ar[i], k[i], d[i], 16'h0001);
            `CHECK(got, 18'h20000)
        end
        `CHECK(operandFaultFlag, 1'b1)
        xfer(operand_pkg::AREA_PLAIN, 4'h3, 16'h0012, 16'h00B0);
        `CHECK(got, 18'h20000)
        xfer(operand_pkg::AREA_PLAIN, 4'h0, 16'h0012, 16'h0000);
        `CHECK(got.wordValue, 16'h8001)
        doReset();
        `CHECK(operandFaultFlag, 1'b0)
    endtask

    initial begin
        for (int i = 0; i < `TC_COUNT; i++) begin
            timerCount[i] = '0;
        end
        doReset();
        wordOps();
        bitOps();
        timerOps();
        indirectOps();
        faultOps();
        completeRun();
    end
endmodule

`default_nettype wire
